// [src/sira_i2c_slave.sv]
// i2c slave register port with index pointer, banks and standby control
`timescale 1ns/1ns
`include "sira_defs.svh"
module sira_i2c_slave
    import sira_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic i2cClk,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic chip_select_n,
    input wire logic frameReflect,
    output logic standbyOut,
    output logic update_freeze_bit,
    output logic [7:0] frameRegOut,
    output logic i2cSelected
);
    // link-side sampling: pins pass three flops on the link clock
    typedef struct packed {
        logic [2:0] scl;
        logic [2:0] sda;
        logic sclQ;
        logic sdaQ;
    } sira_link_s;
    sira_link_s lnk_r;
    always_ff @(posedge i2cClk or posedge rst) begin
        if (rst) begin
            lnk_r <= '{scl: 3'h7, sda: 3'h7, sclQ: 1'b1, sdaQ: 1'b1};
        end else begin
            lnk_r.scl <= {lnk_r.scl[1:0], sclIn};
            lnk_r.sda <= {lnk_r.sda[1:0], sdaIn};
            if (lnk_r.scl[1] == lnk_r.scl[2]) begin
                lnk_r.sclQ <= lnk_r.scl[2];
            end
            if (lnk_r.sda[1] == lnk_r.sda[2]) begin
                lnk_r.sdaQ <= lnk_r.sda[2];
            end
        end
    end
    // filtered levels cross to sys_clk through a 2-flop pair
    logic [1:0] sclSy_r;
    logic [1:0] sdaSy_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sclSy_r <= 2'h3;
            sdaSy_r <= 2'h3;
        end else begin
            sclSy_r <= {sclSy_r[0], lnk_r.sclQ};
            sdaSy_r <= {sdaSy_r[0], lnk_r.sdaQ};
        end
    end
    // frame strobe pin: three flops, a level counts once the last two agree
    logic [2:0] fr_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fr_r <= 3'h0;
        end else begin
            fr_r <= {fr_r[1:0], frameReflect};
        end
    end
    typedef struct packed {
        sira_state_e st;
        logic sclD;
        logic sdaD;
        logic [7:0] sh;
        logic [3:0] bitCnt;
        logic rw;
        logic [1:0] aCnt;
        logic [15:0] idx;
        logic [7:0] standby;
        logic [7:0] hold;
        logic [7:0] frameShadow;
        logic [7:0] frameLive;
        logic framePend;
        logic sdaOe;
        logic ackPh;
        logic modeSel;
        logic modeI2c;
        logic frD;
        logic [7:0] txByte;
        logic memWe;
        logic [15:0] memAddr;
        logic [7:0] memWd;
    } sira_state_s;
    sira_state_s s_r;
    sira_state_s s_nxt;
    logic [7:0] memRd;
    sira_mem_req_s memReq;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic inRange;
    logic [7:0] rdByte;
    assign sclRise = sclSy_r[1] & ~s_r.sclD;
    assign sclFall = ~sclSy_r[1] & s_r.sclD;
    assign startCond = sclSy_r[1] & s_r.sclD & s_r.sdaD & ~sdaSy_r[1];
    assign stopCond = sclSy_r[1] & s_r.sclD & ~s_r.sdaD & sdaSy_r[1];
    assign inRange = (s_r.memAddr[15:8] >= `SIRA_BASE_HI) && (s_r.memAddr[15:8] <= `SIRA_BANK_MAX_HI);
    assign memReq.we = s_r.memWe;
    assign memReq.addr = 11'(s_r.memAddr - `SIRA_STANDBY_ADDR);
    assign memReq.wdata = s_r.memWd;
    sira_bank_mem u_mem (
        .clk(sys_clk),
        .req(memReq),
        .rdata(memRd)
    );
    always_comb begin
        case (s_r.idx)
            `SIRA_STANDBY_ADDR: rdByte = s_r.standby;
            `SIRA_HOLD_ADDR: rdByte = s_r.hold;
            `SIRA_FRAME_ADDR: rdByte = s_r.frameShadow;
            // unmapped locations read as zero, never unknown on the pin
            default: rdByte = inRange ? memRd : 8'h00;
        endcase
    end
    always_comb begin
        s_nxt = s_r;
        s_nxt.sclD = sclSy_r[1];
        s_nxt.sdaD = sdaSy_r[1];
        s_nxt.frD = (fr_r[1] == fr_r[2]) ? fr_r[2] : s_r.frD;
        s_nxt.memWe = 1'b0;
        s_nxt.memAddr = s_r.idx;
        if (!s_r.modeSel && startCond) begin
            s_nxt.modeSel = 1'b1;
            s_nxt.modeI2c = chip_select_n;
        end
        // frame-class value moves live on the reflection edge unless frozen
        if (fr_r[2] && fr_r[1] && !s_r.frD && s_r.framePend && !s_r.hold[`SIRA_HOLD_BIT]) begin
            s_nxt.frameLive = s_r.frameShadow;
            s_nxt.framePend = 1'b0;
        end
        // once four-wire mode is chosen, starts are ignored until reset
        if (startCond && (s_r.modeSel ? s_r.modeI2c : chip_select_n)) begin
            s_nxt.st = SIRA_ADDR;
            s_nxt.bitCnt = 4'h0;
            s_nxt.sdaOe = 1'b0;
            s_nxt.ackPh = 1'b0;
        end else if (stopCond) begin
            s_nxt.st = SIRA_IDLE;
            s_nxt.sdaOe = 1'b0;
        end else begin
            case (s_r.st)
                SIRA_IDLE: begin
                    s_nxt.sdaOe = 1'b0;
                end
                SIRA_SKIP: begin
                    s_nxt.sdaOe = 1'b0;
                end
                SIRA_ADDR, SIRA_RXB: begin
                    if (sclRise && !s_r.ackPh) begin
                        s_nxt.sh = {s_r.sh[6:0], sdaSy_r[1]};
                        s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                    end
                    if (sclFall && s_r.bitCnt == 4'h8 && !s_r.ackPh) begin
                        s_nxt.ackPh = 1'b1;
                        if (s_r.st == SIRA_ADDR) begin
                            if (s_r.sh[7:1] == `SIRA_SLAVE_ADDR) begin
                                s_nxt.sdaOe = 1'b1;
                                s_nxt.rw = s_r.sh[0];
                                s_nxt.aCnt = 2'h0;
                            end else begin
                                s_nxt.st = SIRA_SKIP;
                                s_nxt.ackPh = 1'b0;
                            end
                        end else begin
                            s_nxt.sdaOe = 1'b1;
                            if (s_r.aCnt == 2'h0) begin
                                s_nxt.idx[15:8] = s_r.sh;
                                s_nxt.aCnt = 2'h1;
                            end else if (s_r.aCnt == 2'h1) begin
                                s_nxt.idx[7:0] = s_r.sh;
                                s_nxt.aCnt = 2'h2;
                            end else begin
                                s_nxt.idx = s_r.idx + 16'h0001;
                                s_nxt.memWe = inRange;
                                s_nxt.memWd = s_r.sh;
                                case (s_r.idx)
                                    `SIRA_STANDBY_ADDR: s_nxt.standby = {7'h00, s_r.sh[`SIRA_STANDBY_BIT]};
                                    `SIRA_HOLD_ADDR: s_nxt.hold = {7'h00, s_r.sh[`SIRA_HOLD_BIT]};
                                    `SIRA_FRAME_ADDR: begin
                                        s_nxt.frameShadow = s_r.sh;
                                        s_nxt.framePend = 1'b1;
                                    end
                                    default: s_nxt.memWe = inRange;
                                endcase
                            end
                        end
                    end else if (sclFall && s_r.ackPh) begin
                        s_nxt.sdaOe = 1'b0;
                        s_nxt.ackPh = 1'b0;
                        s_nxt.bitCnt = 4'h0;
                        if (s_r.st == SIRA_ADDR && s_r.rw) begin
                            s_nxt.st = SIRA_TXB;
                            s_nxt.txByte = rdByte;
                            s_nxt.sdaOe = ~rdByte[7];
                            s_nxt.bitCnt = 4'h1;
                        end else begin
                            s_nxt.st = SIRA_RXB;
                        end
                    end
                end
                SIRA_TXB: begin
                    if (sclFall) begin
                        if (s_r.bitCnt == 4'h8) begin
                            s_nxt.sdaOe = 1'b0;
                            s_nxt.st = SIRA_MACK;
                            s_nxt.idx = s_r.idx + 16'h0001;
                        end else begin
                            s_nxt.sdaOe = ~s_r.txByte[3'(4'h7 - s_r.bitCnt)];
                            s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                        end
                    end
                end
                SIRA_MACK: begin
                    s_nxt.sdaOe = 1'b0;
                    if (sclRise) begin
                        s_nxt.ackPh = ~sdaSy_r[1];
                    end
                    if (sclFall) begin
                        if (s_r.ackPh) begin
                            s_nxt.st = SIRA_TXB;
                            s_nxt.txByte = rdByte;
                            s_nxt.sdaOe = ~rdByte[7];
                            s_nxt.bitCnt = 4'h1;
                            s_nxt.ackPh = 1'b0;
                        end else begin
                            s_nxt.st = SIRA_SKIP;
                        end
                    end
                end
                default: begin
                    s_nxt.st = SIRA_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_r <= '{st: SIRA_IDLE, sclD: 1'b1, sdaD: 1'b1, standby: `SIRA_STANDBY_RST, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end
    logic standby_r;
    logic hold_r;
    logic [7:0] frame_r;
    logic oe_r;
    logic sel_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            standby_r <= 1'b1;
            hold_r <= 1'b0;
            frame_r <= 8'h00;
            oe_r <= 1'b0;
            sel_r <= 1'b0;
        end else begin
            standby_r <= s_nxt.standby[`SIRA_STANDBY_BIT];
            hold_r <= s_nxt.hold[`SIRA_HOLD_BIT];
            frame_r <= s_nxt.frameLive;
            oe_r <= s_nxt.sdaOe;
            sel_r <= s_nxt.modeSel & s_nxt.modeI2c;
        end
    end
    assign standbyOut = standby_r;
    assign update_freeze_bit = hold_r;
    assign frameRegOut = frame_r;
    assign sdaOe = oe_r;
    assign sdaOut = 1'b0;
    assign i2cSelected = sel_r;

    chk_standby_reset: assert property (@(posedge sys_clk) $fell(rst) |-> standbyOut)
        else $error("standby not set after reset");
    chk_open_drain: assert property (@(posedge sys_clk) disable iff (rst) !sdaOut)
        else $error("sda driven high");
    chk_frame_hold: assert property (@(posedge sys_clk) disable iff (rst)
        s_r.hold[0] |=> $stable(frameRegOut))
        else $error("frame register moved under hold");
    chk_idx_inc: assert property (@(posedge sys_clk) disable iff (rst)
        (s_r.st == SIRA_TXB && sclFall && s_r.bitCnt == 4'h8) |=> s_r.idx == $past(s_r.idx) + 16'h0001)
        else $error("index not advanced after read byte");
    chk_wr_store: assert property (@(posedge sys_clk) disable iff (rst)
        (s_r.memWe) |-> s_r.idx == s_r.memAddr + 16'h0001)
        else $error("write not paired with index advance");
    chk_standby_imm: assert property (@(posedge sys_clk) disable iff (rst)
        (s_nxt.standby != s_r.standby) |=> standbyOut == s_r.standby[0])
        else $error("standby not applied at once");
    chk_rstart_idx: assert property (@(posedge sys_clk) disable iff (rst)
        (startCond && s_r.st != SIRA_IDLE) |=> s_r.idx == $past(s_r.idx))
        else $error("index lost on repeated start");
    chk_ack_release: assert property (@(posedge sys_clk) disable iff (rst)
        (s_r.ackPh && sclFall && s_r.st == SIRA_RXB) |=> !s_r.sdaOe)
        else $error("sda held after ack");
    chk_addr_match: assert property (@(posedge sys_clk) disable iff (rst)
        (s_r.st == SIRA_ADDR && sclFall && s_r.bitCnt == 4'h8 && !s_r.ackPh && s_r.sh[7:1] != 7'h1A)
        |=> s_r.st == SIRA_SKIP)
        else $error("foreign address answered");
    cov_read: cover property (@(posedge sys_clk) s_r.st == SIRA_TXB);
    cov_write: cover property (@(posedge sys_clk) s_r.memWe);
    cov_reflect: cover property (@(posedge sys_clk) $changed(frameRegOut));
endmodule : sira_i2c_slave

// [common/sira_defs.svh]
// addresses, offsets, field positions and reset values of the sensor i2c register port
`ifndef SIRA_DEFS_SVH
`define SIRA_DEFS_SVH
`define SIRA_SLAVE_ADDR 7'h1A
`define SIRA_BASE_HI 8'h30
`define SIRA_BANK_MAX_HI 8'h34
`define SIRA_STANDBY_ADDR 16'h3000
`define SIRA_HOLD_ADDR 16'h3001
`define SIRA_STANDBY_BIT 0
`define SIRA_HOLD_BIT 0
`define SIRA_STANDBY_RST 8'h01
`define SIRA_MEM_AW 11
`define SIRA_FRAME_ADDR 16'h3014
`endif

// [common/sira_pkg.sv]
// types of the sensor i2c register port
package sira_pkg;
    typedef enum logic [5:0] {
        SIRA_IDLE = 6'b000001,
        SIRA_ADDR = 6'b000010,
        SIRA_RXB = 6'b000100,
        SIRA_TXB = 6'b001000,
        SIRA_MACK = 6'b010000,
        SIRA_SKIP = 6'b100000
    } sira_state_e;
    typedef struct packed {
        logic we;
        logic [10:0] addr;
        logic [7:0] wdata;
    } sira_mem_req_s;
endpackage : sira_pkg

// [src/sira_bank_mem.sv]
// five 256-byte register banks with registered read data
`timescale 1ns/1ns
module sira_bank_mem
    import sira_pkg::*;
(
    input wire logic clk,
    input wire sira_mem_req_s req,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:1279];
    always_ff @(posedge clk) begin
        if (req.we) begin
            mem[req.addr] <= req.wdata;
        end
        rdata <= mem[req.addr];
    end
endmodule : sira_bank_mem

// [tb/sira_host_model.sv]
// i2c bus master model with open-drain sda and its own scl
`timescale 1ns/1ns
`include "sira_defs.svh"
module sira_host_model (
    input wire logic clk,
    input wire logic sdaLine,
    output logic sclOut,
    output logic sdaRel
);
    // quarter of an scl period in system clocks, half period 500 ns
    localparam int QTR = 25;
    initial begin
        sclOut = 1'b1;
        sdaRel = 1'b1;
    end
    task automatic waitq(input int n);
        repeat (n * QTR) @(negedge clk);
    endtask : waitq
    // start and repeated start alike
    task automatic startCond();
        sdaRel = 1'b1;
        waitq(1);
        sclOut = 1'b1;
        waitq(1);
        sdaRel = 1'b0;
        waitq(1);
        sclOut = 1'b0;
        waitq(1);
    endtask : startCond
    task automatic stopCond();
        sdaRel = 1'b0;
        waitq(1);
        sclOut = 1'b1;
        waitq(1);
        sdaRel = 1'b1;
        waitq(2);
    endtask : stopCond
    // sda moves only while scl is low
    task automatic clkBit(input logic v, output logic s);
        sdaRel = v;
        waitq(1);
        sclOut = 1'b1;
        waitq(1);
        s = sdaLine;
        waitq(1);
        sclOut = 1'b0;
        waitq(1);
    endtask : clkBit
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clkBit(b[i], s);
        clkBit(1'b1, s);
        ack = !s;
    endtask : sendByte
    task automatic recvByte(input logic ackIt, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) clkBit(1'b1, b[i]);
        clkBit(!ackIt, s);
    endtask : recvByte
    task automatic probe(input logic [6:0] sa, output logic ack);
        startCond();
        sendByte({sa, 1'b0}, ack);
        stopCond();
    endtask : probe
    // address big-endian, then data bytes
    task automatic writeRegs(input logic [15:0] a, input logic [7:0] d[$], output logic ok);
        logic ack;
        startCond();
        sendByte({`SIRA_SLAVE_ADDR, 1'b0}, ok);
        if (ok) sendByte(a[15:8], ok);
        if (ok) sendByte(a[7:0], ok);
        foreach (d[i]) begin
            if (ok) sendByte(d[i], ok);
        end
        stopCond();
    endtask : writeRegs
    task automatic readRegs(input logic setAddr, input logic [15:0] a, input int n, output logic ok,
                            output logic [7:0] q[$]);
        logic [7:0] b;
        ok = 1'b1;
        q = {};
        if (setAddr) begin
            startCond();
            sendByte({`SIRA_SLAVE_ADDR, 1'b0}, ok);
            if (ok) sendByte(a[15:8], ok);
            if (ok) sendByte(a[7:0], ok);
        end
        if (ok) startCond();
        if (ok) sendByte({`SIRA_SLAVE_ADDR, 1'b1}, ok);
        for (int i = 0; i < n && ok; i++) begin
            recvByte(i < n - 1, b);
            q.push_back(b);
        end
        stopCond();
    endtask : readRegs
endmodule : sira_host_model

// [tb/sira_i2c_slave_bench.sv]
// self-checking bench of the sensor i2c register port
`timescale 1ns/1ns
module sira_i2c_slave_bench import sira_pkg::*;;
    typedef struct packed {logic [15:0] addr; logic [7:0] wdata; logic [7:0] rdExp; logic sby;} sira_row_s;
    localparam sira_row_s ROWS [4] = '{'{16'h3000, 8'hFF, 8'h01, 1'b1}, '{16'h3000, 8'h00, 8'h00, 1'b0},
        '{16'h3100, 8'hA5, 8'hA5, 1'b0}, '{16'h34FF, 8'h5A, 8'h5A, 1'b0}};
    logic sysClk = 1'b0;
    logic i2cClk = 1'b0;
    logic rst = 1'b1;
    logic frameReflect = 1'b0;
    logic chipSelectN = 1'b1;
    logic sclOut, sdaRel, sdaOut, sdaOe, standbyOut, freezeBit, i2cSelected, ok;
    logic [7:0] frameRegOut;
    logic [7:0] q[$];
    wire logic sdaLine;
    int errTotal = 0;
    int checksDone = 0;
    always #5 sysClk = ~sysClk;
    initial begin
        #3;
        forever #15 i2cClk = ~i2cClk;
    end
    // pull-up on sda, low while any party pulls
    assign sdaLine = sdaRel & ~(sdaOe & ~sdaOut);
    sira_i2c_slave sira_i2c_slave_i (.sys_clk(sysClk), .rst(rst), .i2cClk(i2cClk), .sclIn(sclOut),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .chip_select_n(chipSelectN),
        .frameReflect(frameReflect), .standbyOut(standbyOut), .update_freeze_bit(freezeBit),
        .frameRegOut(frameRegOut), .i2cSelected(i2cSelected));
    sira_host_model sira_host_model_i (.clk(sysClk), .sdaLine(sdaLine), .sclOut(sclOut), .sdaRel(sdaRel));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errTotal++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : printVerdict
    task automatic reflect();
        frameReflect = 1'b1;
        repeat (4) @(negedge sysClk);
        frameReflect = 1'b0;
        repeat (10) @(negedge sysClk);
    endtask : reflect
    task automatic wr1(input logic [15:0] a, input logic [7:0] d);
        sira_host_model_i.writeRegs(a, '{d}, ok);
        check("write ack", ok, 1'b1);
    endtask : wr1
    initial begin
        repeat (100000) @(posedge sysClk);
        errTotal++;
        printVerdict();
    end
    initial begin
        repeat (6) @(negedge sysClk);
        rst = 1'b0;
        repeat (10) @(negedge sysClk);
        check("standby reset", standbyOut, 1'b1);
        check("hold reset", freezeBit, 1'b0);
        check("oe reset", sdaOe, 1'b0);
        check("sda out low", sdaOut, 1'b0);
        check("mode reset", i2cSelected, 1'b0);
        sira_host_model_i.readRegs(1'b1, 16'h3000, 1, ok, q);
        check("read ack", ok, 1'b1);
        check("standby read", q[0], 8'h01);
        check("mode latched", i2cSelected, 1'b1);
        $display("test reset done");
        foreach (ROWS[i]) begin
            wr1(ROWS[i].addr, ROWS[i].wdata);
            check("standby out", standbyOut, ROWS[i].sby);
            sira_host_model_i.readRegs(1'b1, ROWS[i].addr, 1, ok, q);
            check("readback", q[0], ROWS[i].rdExp);
        end
        $display("test rows done");
        sira_host_model_i.writeRegs(16'h3200, '{8'h11, 8'h22, 8'h33, 8'h44}, ok);
        check("seq write ack", ok, 1'b1);
        sira_host_model_i.readRegs(1'b1, 16'h3200, 3, ok, q);
        check("seq read ack", ok, 1'b1);
        check("seq read count", 8'(q.size()), 8'h03);
        foreach (q[i]) check("seq read", q[i], 8'(8'h11 * (i + 1)));
        sira_host_model_i.readRegs(1'b0, 16'h0000, 1, ok, q);
        check("current read", q[0], 8'h44);
        $display("test sequential done");
        sira_host_model_i.probe(7'h2B, ok);
        check("foreign ack", ok, 1'b0);
        wr1(16'h3500, 8'hAA);
        sira_host_model_i.readRegs(1'b1, 16'h3500, 1, ok, q);
        check("unmapped read", q[0], 8'h00);
        $display("test refusal done");
        check("frame idle", frameRegOut, 8'h00);
        wr1(16'h3014, 8'h3C);
        check("frame deferred", frameRegOut, 8'h00);
        reflect();
        check("frame applied", frameRegOut, 8'h3C);
        wr1(16'h3001, 8'h01);
        check("hold set", freezeBit, 1'b1);
        wr1(16'h3014, 8'h77);
        reflect();
        check("frame held", frameRegOut, 8'h3C);
        wr1(16'h3001, 8'h00);
        reflect();
        check("frame released", frameRegOut, 8'h77);
        $display("test frame done");
        rst = 1'b1;
        repeat (6) @(negedge sysClk);
        rst = 1'b0;
        chipSelectN = 1'b0;
        repeat (10) @(negedge sysClk);
        check("standby after reset", standbyOut, 1'b1);
        check("mode after reset", i2cSelected, 1'b0);
        sira_host_model_i.probe(7'h1A, ok);
        check("four wire ack", ok, 1'b0);
        chipSelectN = 1'b1;
        sira_host_model_i.probe(7'h1A, ok);
        check("choice kept ack", ok, 1'b0);
        check("choice kept mode", i2cSelected, 1'b0);
        $display("test mode done");
        printVerdict();
    end
endmodule : sira_i2c_slave_bench
